// *** pdg_gate.sv ***
// power-down entry gate: accept, ignore or quasi-idle decision
`timescale 1ns/1ps
`default_nettype none
module pdg_gate
	import pdg_pkg::*;
#(
	parameter int P2W = pdg_port2_width
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_reset,
	// instruction decode side
	input wire logic i_power_down_request,
	input wire logic i_next_fetch_external,
	input wire logic i_prev_write_external,
	input wire logic i_bus_multiplexed,
	input wire logic i_tristate_wait_control_bit,
	// configuration
	input wire logic i_wake_source_select_bit,
	input wire logic [P2W-1:0] i_port2_exit_enable,
	input wire logic [P2W-1:0] i_port2_active_high,
	// pins
	input wire logic i_nmi_pin,
	input wire logic [P2W-1:0] i_port2_pin,
	// watchdog
	input wire logic i_watchdog_overflow,
	// status outputs
	output logic o_power_down,
	output logic o_quasi_idle,
	output logic o_fetch_stall,
	output logic o_interrupt_block,
	output logic o_request_ignored,
	output logic o_watchdog_reset
);
	// state, next values and synced pin levels
	pdg_state_t state;
	pdg_state_t next_state;
	logic next_ignored;
	logic next_wd_reset;
	logic next_power_down;
	logic next_quasi_idle;
	logic next_fetch_stall;
	logic next_interrupt_block;
	logic nmi_level;
	logic [P2W-1:0] port2_level;
	logic wake_active;
	logic quasi_case;

	// pins cross into the cpu clock through three stages
	pdg_sync #(.WIDTH(1)) u_nmi_sync (
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_pin(i_nmi_pin),
		.i_init(1'b0),
		.o_level(nmi_level)
	);
	pdg_sync #(.WIDTH(P2W)) u_p2_sync (
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_pin(i_port2_pin),
		.i_init('0),
		.o_level(port2_level)
	);

	// wake source active decision from the selected source
	// a port 2 pin counts only when enabled and at its active level
	function automatic logic wake_src(input logic sel, input logic nmi,
			input logic [P2W-1:0] lvl, input logic [P2W-1:0] en,
			input logic [P2W-1:0] hi);
		logic [P2W-1:0] act;
		act = ~(lvl ^ hi) & en;
		if (sel == pdg_wake_nmi) begin
			wake_src = nmi;
		end else begin
			wake_src = |act;
		end
	endfunction

	assign wake_active = wake_src(i_wake_source_select_bit, nmi_level, port2_level,
		i_port2_exit_enable, i_port2_active_high);
	// quasi-idle hazard: fetch stalls instead of an ignore or a clean entry
	assign quasi_case = i_next_fetch_external &&
		((i_bus_multiplexed && !i_tristate_wait_control_bit)
		|| i_prev_write_external);

	// next state of the gate
	always_comb begin
		next_state = state;
		next_ignored = 1'b0;
		// overflow pulse passes on except in power-down
		next_wd_reset = i_watchdog_overflow && (state != pdg_down_s);
		case (state)
			pdg_run_s: begin
				if (i_power_down_request) begin
					// hazard case wins over an ignore when both apply
					if (wake_active && !quasi_case) begin
						next_ignored = 1'b1;
					end else if (quasi_case) begin
						next_state = pdg_quasi_s;
					end else begin
						next_state = pdg_down_s;
					end
				end
			end
			pdg_quasi_s: begin
				if (i_watchdog_overflow) begin
					next_state = pdg_run_s;
				end else if (!nmi_level) begin
					next_state = pdg_down_s;
				end
			end
			pdg_down_s: begin
				// no wake path here, left only by reset
				next_state = pdg_down_s;
			end
			default: begin
				next_state = pdg_run_s;
			end
		endcase
		// status follows the state being entered
		next_power_down = (next_state == pdg_down_s);
		next_quasi_idle = (next_state == pdg_quasi_s);
		next_fetch_stall = (next_state != pdg_run_s);
		next_interrupt_block = (next_state == pdg_quasi_s);
	end

	// register state and outputs
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			state <= pdg_run_s;
			o_power_down <= 1'b0;
			o_quasi_idle <= 1'b0;
			o_fetch_stall <= 1'b0;
			o_interrupt_block <= 1'b0;
			o_request_ignored <= 1'b0;
			o_watchdog_reset <= 1'b0;
		end else begin
			state <= next_state;
			o_power_down <= next_power_down;
			o_quasi_idle <= next_quasi_idle;
			o_fetch_stall <= next_fetch_stall;
			o_interrupt_block <= next_interrupt_block;
			o_request_ignored <= next_ignored;
			o_watchdog_reset <= next_wd_reset;
		end
	end

	// checks
	chk_ignore_nmi: assert property (@(posedge i_clock) disable iff (i_reset)
		(state == pdg_run_s && i_power_down_request && !i_wake_source_select_bit
		&& nmi_level && !quasi_case) |=> o_request_ignored && !o_power_down)
		else $error("request not ignored with wake pin high");
	chk_ignore_port2: assert property (@(posedge i_clock) disable iff (i_reset)
		(state == pdg_run_s && i_power_down_request && i_wake_source_select_bit
		&& |(~(port2_level ^ i_port2_active_high) & i_port2_exit_enable)
		&& !quasi_case) |=> o_request_ignored && !o_power_down)
		else $error("request not ignored with port 2 pin active");
	chk_enter_down: assert property (@(posedge i_clock) disable iff (i_reset)
		(state == pdg_run_s && i_power_down_request && !wake_active && !quasi_case)
		|=> o_power_down && !o_quasi_idle)
		else $error("power-down not entered");
	chk_quasi_mux: assert property (@(posedge i_clock) disable iff (i_reset)
		(state == pdg_run_s && i_power_down_request && i_next_fetch_external
		&& i_bus_multiplexed && !i_tristate_wait_control_bit)
		|=> o_quasi_idle && o_fetch_stall)
		else $error("quasi idle not entered on mux wait bus");
	chk_quasi_write: assert property (@(posedge i_clock) disable iff (i_reset)
		(state == pdg_run_s && i_power_down_request && i_next_fetch_external
		&& i_prev_write_external) |=> o_quasi_idle)
		else $error("quasi idle not entered after external write");
	chk_quasi_block: assert property (@(posedge i_clock) disable iff (i_reset)
		o_quasi_idle |-> o_interrupt_block && o_fetch_stall && !o_power_down)
		else $error("interrupts not blocked in quasi idle");
	chk_quasi_wdog: assert property (@(posedge i_clock) disable iff (i_reset)
		(o_quasi_idle && i_watchdog_overflow) |=> o_watchdog_reset && !o_quasi_idle)
		else $error("watchdog reset missing in quasi idle");
	chk_quasi_exit: assert property (@(posedge i_clock) disable iff (i_reset)
		(state == pdg_quasi_s && !nmi_level && !i_watchdog_overflow)
		|=> o_power_down ##1 o_power_down)
		else $error("quasi idle did not reach power-down");
	chk_run_idle: assert property (@(posedge i_clock) disable iff (i_reset)
		(state == pdg_run_s && !i_power_down_request) |=> !$rose(o_power_down)
		&& !o_request_ignored)
		else $error("decision without request pulse");
	// sticky, quiet and hold checks
	chk_down_sticky: assert property (@(posedge i_clock) disable iff (i_reset)
		o_power_down |=> o_power_down)
		else $error("power-down left without reset");
	chk_refused_quiet: assert property (@(posedge i_clock) disable iff (i_reset)
		(state != pdg_run_s && i_power_down_request) |=> !o_request_ignored)
		else $error("request outside run state answered");
	chk_wdog_quiet: assert property (@(posedge i_clock) disable iff (i_reset)
		!i_watchdog_overflow |=> !o_watchdog_reset)
		else $error("watchdog reset without overflow");
	chk_down_no_wdog: assert property (@(posedge i_clock) disable iff (i_reset)
		(o_power_down && i_watchdog_overflow) |=> !o_watchdog_reset)
		else $error("watchdog reset during power-down");
	chk_ignore_running: assert property (@(posedge i_clock) disable iff (i_reset)
		o_request_ignored |-> !o_fetch_stall && !o_power_down && !o_quasi_idle)
		else $error("ignored request did not keep running");
	chk_quasi_hold: assert property (@(posedge i_clock) disable iff (i_reset)
		(state == pdg_quasi_s && nmi_level && !i_watchdog_overflow)
		|=> o_quasi_idle && !o_power_down)
		else $error("quasi idle left with wake pin high");

	// main scenarios reached
	cov_ignored: cover property (@(posedge i_clock) disable iff (i_reset)
		o_request_ignored);
	cov_down: cover property (@(posedge i_clock) disable iff (i_reset)
		$rose(o_power_down) && $past(state) == pdg_run_s);
	cov_quasi_down: cover property (@(posedge i_clock) disable iff (i_reset)
		o_quasi_idle ##1 o_power_down);
	cov_quasi_wdog: cover property (@(posedge i_clock) disable iff (i_reset)
		o_quasi_idle ##1 o_watchdog_reset);
	cov_p2_ignore: cover property (@(posedge i_clock) disable iff (i_reset)
		o_request_ignored && i_wake_source_select_bit);
endmodule // pdg_gate
`default_nettype wire

// *** pdg_pins_model.sv ***
// pin-side model: drives the wake pins
`timescale 1ns/1ps
`default_nettype none
module pdg_pins_model (
	// clock
	input wire logic i_clock,
	// levels asked for by the bench
	input wire logic i_nmi_level,
	input wire logic [15:0] i_p2_level,
	// pin levels
	output logic o_nmi_pin,
	output logic [15:0] o_port2_pin
);
	// push-pull pins, change just after an edge
	always_ff @(posedge i_clock) begin
		o_nmi_pin <= i_nmi_level;
		o_port2_pin <= i_p2_level;
	end
endmodule // pdg_pins_model
`default_nettype wire

// *** pdg_pkg.sv ***
// constants and types for the power-down entry gate
`default_nettype none
package pdg_pkg;
	// wake source select encodings
	localparam logic pdg_wake_nmi = 1'b0;
	localparam logic pdg_wake_port2 = 1'b1;
	// default port 2 wake pin count
	localparam int pdg_port2_width = 16;
	// synchroniser depth for pin inputs
	localparam int pdg_sync_depth = 3;
	// gate states, gray coded along running -> quasi idle -> power down
	typedef enum logic [1:0] {
		pdg_run_s = 2'b00,
		pdg_quasi_s = 2'b01,
		pdg_down_s = 2'b11
	} pdg_state_t;
endpackage
`default_nettype wire

// *** pdg_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pdg_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_reset,
	// raw pin levels and reset value
	input wire logic [WIDTH-1:0] i_pin,
	input wire logic [WIDTH-1:0] i_init,
	// filtered level
	output logic [WIDTH-1:0] o_level
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] next_level;

	// change taken only when stage two and three agree
	always_comb begin
		next_level = o_level;
		for (int b = 0; b < WIDTH; b++) begin
			if (stage2[b] == stage3[b]) begin
				next_level[b] = stage3[b];
			end
		end
	end

	// shift stages, reset value comes from a constant tie at the parent
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			stage1 <= i_init;
			stage2 <= i_init;
			stage3 <= i_init;
			o_level <= i_init;
		end else begin
			stage1 <= i_pin;
			stage2 <= stage1;
			stage3 <= stage2;
			o_level <= next_level;
		end
	end
endmodule // pdg_sync
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the power-down entry gate
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
	$display("FAIL %s exp %0h got %0h", nm, e, g); end end
module tb_top;
	import pdg_pkg::*;
	logic i_clock, i_reset, req, nfe, pwe, mux, twb, sel, nmi_l, wd;
	logic [15:0] en, hi, p2_l;
	wire logic nmi;
	wire logic [15:0] p2;
	logic pd, qi, fs, ib, ri, wr;
	int error_cnt = 0;
	int n_tests = 0;
	int c;
	pdg_pins_model pdg_pins_model_inst (.i_clock(i_clock), .i_nmi_level(nmi_l),
		.i_p2_level(p2_l), .o_nmi_pin(nmi), .o_port2_pin(p2));
	pdg_gate pdg_gate_inst (.i_clock(i_clock), .i_reset(i_reset), .i_power_down_request(req),
		.i_next_fetch_external(nfe), .i_prev_write_external(pwe), .i_bus_multiplexed(mux),
		.i_tristate_wait_control_bit(twb), .i_wake_source_select_bit(sel),
		.i_port2_exit_enable(en), .i_port2_active_high(hi), .i_nmi_pin(nmi),
		.i_port2_pin(p2), .i_watchdog_overflow(wd), .o_power_down(pd), .o_quasi_idle(qi),
		.o_fetch_stall(fs), .o_interrupt_block(ib), .o_request_ignored(ri),
		.o_watchdog_reset(wr));
	// clock
	initial begin
		i_clock = 0;
		forever #10 i_clock = ~i_clock;
	end
	// verdict
	task end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// reset with quiet inputs, bit 3 the only exit pin
	task rst_all(input logic s);
		@(posedge i_clock);
		i_reset <= 1;
		req <= 0;
		pwe <= 0;
		{nfe, mux, twb, sel, nmi_l, wd} <= {3'b001, s, 2'b10};
		{en, hi, p2_l} <= {16'h0008, 16'h0008, 16'h0000};
		repeat (16) @(posedge i_clock);
		i_reset <= 0;
		repeat (6) @(posedge i_clock);
	endtask
	// set pins, one request, count ignore pulses
	task try(input logic [15:0] lv, input logic [15:0] h, input logic n, input int ec,
		input logic ed);
		@(posedge i_clock);
		{p2_l, hi, nmi_l} <= {lv, h, n};
		repeat (8) @(posedge i_clock);
		req <= 1;
		@(posedge i_clock);
		req <= 0;
		c = 0;
		repeat (4) begin
			#1 if (ri === 1'b1) c++;
			@(posedge i_clock);
		end
		#1;
		`CHK("ignored pulses", ec, c)
		`CHK("power down", ed, pd)
	endtask
	task t_nmi;
		rst_all(pdg_wake_nmi);
		try(16'h0000, 16'h0008, 1'b1, 1, 1'b0);
		try(16'h0008, 16'h0008, 1'b0, 0, 1'b1);
		`CHK("stall", 1'b1, fs)
		$display("test nmi done");
	endtask
	task t_p2;
		rst_all(pdg_wake_port2);
		try(16'h0008, 16'h0008, 1'b0, 1, 1'b0);
		try(16'h0000, 16'h0000, 1'b0, 1, 1'b0);
		try(16'hfff7, 16'h0008, 1'b1, 0, 1'b1);
		$display("test port2 done");
	endtask
	task t_quasi;
		rst_all(pdg_wake_nmi);
		{nfe, mux, twb} <= 3'b110;
		try(16'h0000, 16'h0008, 1'b1, 0, 1'b0);
		`CHK("quasi", 1'b1, qi)
		`CHK("int block", 1'b1, ib)
		`CHK("stall", 1'b1, fs)
		nmi_l <= 0;
		repeat (8) @(posedge i_clock);
		#1;
		`CHK("down after nmi", 1'b1, pd)
		`CHK("quasi left", 1'b0, qi)
		$display("test quasi done");
	endtask
	task t_wd;
		rst_all(pdg_wake_nmi);
		{nfe, mux, twb} <= 3'b111;
		try(16'h0000, 16'h0008, 1'b1, 1, 1'b0);
		`CHK("no quasi", 1'b0, qi)
		@(posedge i_clock);
		pwe <= 1;
		try(16'h0000, 16'h0008, 1'b1, 0, 1'b0);
		`CHK("quasi", 1'b1, qi)
		@(posedge i_clock);
		wd <= 1;
		@(posedge i_clock);
		wd <= 0;
		c = 0;
		repeat (4) begin
			#1 if (wr === 1'b1) c++;
			@(posedge i_clock);
		end
		`CHK("wd resets", 1, c)
		$display("test watchdog done");
	endtask
	// main sequence
	initial begin
		{i_reset, req, nfe, pwe, mux, twb, sel, nmi_l, wd} = 9'h100;
		{en, hi, p2_l} = 48'h0;
		t_nmi();
		t_p2();
		t_quasi();
		t_wd();
		end_sim();
	end
	// hang guard, about 2000 cycles
	initial begin
		#40000;
		error_cnt++;
		end_sim();
	end
endmodule // tb_top
`default_nettype wire
